// file: dsp_decoder_pkg.sv
// Constants, types and decode functions for the instruction decoder
// Contract
// - 0xE3 with 0x44 branches on negative, 4/2
// - Mask and state 1000 branch on zero
// - 0xBE30 indirect call through accumulator, 4 cycles
// - 0xBF44-0xBF47 compares current aux with zero
// - 0xAF port input, two words, 2 cycles
// - 0x6B load accumulator, shift from temp, 1
// - 0x8B88-0x8B8F loads aux pointer, one cycle
// - 1011110P immediate page load, 2 cycles
// - 0x0E loads status word zero, 2 cycles
// - 0x70 temp load plus accumulate product, 1
// - 0x71 temp load, product into accumulator
// - 0xA3 two-word multiply-accumulate-move, 3 cycles
// - 0x50 multiply-add, 0x51 multiply-subtract, one cycle
// - 0xA0 one-cycle accumulator normalize step
// - 0xBE3C pushes low accumulator, 0xBE32 pops
// - 111011TP conditional return, 4 taken, 2 not
// - 0xBB immediate repeat, 0x0B memory-count repeat
// - 10011SHF store high, 10010SHF store low
// - 0xBE05 subtracts product from accumulator
// - 0x53 square and subtract previous product
// - 0x64 subtract with inverted carry borrow
// - 0x68 zero low, load high, round
// - Select 00 bio low, 01/10 test, 11 none
// - Masked flag matching state bit meets condition
// - Repeat N runs N+1 times, interrupts masked
package dsp_decoder_pkg;

  // ----------------------------------------
  // Register map and reset values
  // ----------------------------------------
  localparam int AXI_ADDR_W = 8;
  localparam logic [7:0] OFS_WORD0 = 8'h00;
  localparam logic [7:0] OFS_WORD1 = 8'h04;
  localparam logic [7:0] OFS_FLAGS = 8'h08;
  localparam logic [7:0] OFS_CMD = 8'h0C;
  localparam logic [7:0] OFS_RESULT = 8'h10;
  localparam logic [7:0] OFS_REPEAT = 8'h14;
  localparam logic [15:0] WORD_RST = 16'h8B00;
  localparam logic [5:0] FLAGS_RST = 6'h20;
  localparam logic [15:0] RPT_RST = 16'h0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Flag bit positions
  localparam int FLAG_C = 0;
  localparam int FLAG_V = 1;
  localparam int FLAG_L = 2;
  localparam int FLAG_Z = 3;
  localparam int FLAG_TC = 4;
  localparam int FLAG_BIO = 5;

  // Result and repeat register field positions
  localparam int RES_WORDS_LSB = 8;
  localparam int RES_CYC_LSB = 12;
  localparam int RES_COND_BIT = 16;
  localparam int RES_ILL_BIT = 17;
  localparam int RES_FIELD_LSB = 20;
  localparam int RPT_ACTIVE_BIT = 16;

  // Cycle and word counts
  localparam logic [1:0] WORDS_ONE = 2'h1;
  localparam logic [1:0] WORDS_TWO = 2'h2;
  localparam logic [2:0] CYC_ONE = 3'h1;
  localparam logic [2:0] CYC_TWO = 3'h2;
  localparam logic [2:0] CYC_THREE = 3'h3;
  localparam logic [2:0] CYC_FOUR = 3'h4;

  typedef enum logic [4:0] {
    illegal_op = 5'h00,
    cond_branch_op = 5'h01,
    call_indirect_op = 5'h02,
    aux_compare_op = 5'h03,
    port_in_op = 5'h04,
    load_acc_tshift_op = 5'h05,
    aux_modify_op = 5'h06,
    page_load_op = 5'h07,
    status_load_op = 5'h08,
    tload_accum_op = 5'h09,
    tload_prodmove_op = 5'h0A,
    mac_move_op = 5'h0B,
    mul_add_prev_op = 5'h0C,
    mul_sub_prev_op = 5'h0D,
    normalize_op = 5'h0E,
    push_acc_op = 5'h0F,
    pop_acc_op = 5'h10,
    cond_return_op = 5'h11,
    repeat_imm_op = 5'h12,
    repeat_mem_op = 5'h13,
    store_acc_high_op = 5'h14,
    store_acc_low_op = 5'h15,
    sub_product_op = 5'h16,
    square_sub_op = 5'h17,
    sub_borrow_op = 5'h18,
    zero_load_round_op = 5'h19,
    cond_call_op = 5'h1A
  } op_t;

  // ----------------------------------------
  // Decode functions
  // ----------------------------------------
  function automatic op_t decode_word(input logic [15:0] w);
    op_t op;
    op = illegal_op;
    if (w[15:10] == 6'h38) op = cond_branch_op;
    else if (w[15:10] == 6'h3A) op = cond_call_op;
    else if (w[15:10] == 6'h3B) op = cond_return_op;
    else if (w == 16'hBE30) op = call_indirect_op;
    else if (w == 16'hBE3C) op = push_acc_op;
    else if (w == 16'hBE32) op = pop_acc_op;
    else if (w == 16'hBE05) op = sub_product_op;
    else if (w[15:2] == 14'h2FD1) op = aux_compare_op;
    else if (w[15:3] == 13'h1171) op = aux_modify_op;
    else if (w[15:9] == 7'h5E) op = page_load_op;
    else if (w[15:12] == 4'h9) op = w[11] ? store_acc_high_op : store_acc_low_op;
    else begin
      case (w[15:8])
        8'hAF: op = port_in_op;
        8'h6B: op = load_acc_tshift_op;
        8'h0E: op = status_load_op;
        8'h70: op = tload_accum_op;
        8'h71: op = tload_prodmove_op;
        8'hA3: op = mac_move_op;
        8'h50: op = mul_add_prev_op;
        8'h51: op = mul_sub_prev_op;
        8'hA0: op = normalize_op;
        8'hBB: op = repeat_imm_op;
        8'h0B: op = repeat_mem_op;
        8'h53: op = square_sub_op;
        8'h64: op = sub_borrow_op;
        8'h68: op = zero_load_round_op;
        default: op = illegal_op;
      endcase
    end
    return op;
  endfunction

  // Select field and mask/state test combined; an empty mask tests nothing
  function automatic logic cond_holds(input logic [15:0] w, input logic [5:0] f);
    logic sel_ok;
    logic cond_mask_field_ok;
    case (w[9:8])
      2'h0: sel_ok = ~f[FLAG_BIO];
      2'h1: sel_ok = f[FLAG_TC];
      2'h2: sel_ok = ~f[FLAG_TC];
      default: sel_ok = 1'b1;
    endcase
    cond_mask_field_ok = (w[3:0] == 4'h0) | (|(w[3:0] & ~(w[7:4] ^ f[3:0])));
    return sel_ok & cond_mask_field_ok;
  endfunction

  function automatic logic [1:0] words_of(input op_t op);
    case (op)
      cond_branch_op, cond_call_op, port_in_op, mac_move_op: return WORDS_TWO;
      default: return WORDS_ONE;
    endcase
  endfunction

  function automatic logic [2:0] cycles_of(input op_t op, input logic taken);
    case (op)
      cond_branch_op, cond_call_op, cond_return_op: return taken ? CYC_FOUR : CYC_TWO;
      call_indirect_op: return CYC_FOUR;
      mac_move_op: return CYC_THREE;
      port_in_op, page_load_op, status_load_op: return CYC_TWO;
      default: return CYC_ONE;
    endcase
  endfunction

endpackage

// file: dsp_instruction_decoder.sv
// Instruction decoder with repeat control and an AXI4-Lite register window
`timescale 1ns/1ps
module dsp_instruction_decoder (
  input wire logic clk,
  input wire logic rst,
  input wire logic instr_valid,
  input wire logic [15:0] instr_word0,
  input wire logic [15:0] instr_word1,
  input wire logic [15:0] rpt_mem_count,
  input wire logic hold_req,
  output logic dec_valid,
  output logic [4:0] dec_op,
  output logic [1:0] dec_words,
  output logic [2:0] dec_cycles,
  output logic dec_cond,
  output logic dec_illegal,
  output logic [8:0] dec_field,
  output logic [15:0] dec_operand,
  output logic irq_block,
  output logic rpt_active,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic [15:0] word0_reg;
  logic [15:0] word1_reg;
  logic [5:0] flags_reg;
  logic go_reg;
  logic hold_meta_reg;
  logic hold_sync_reg;
  logic aw_have_reg;
  logic w_have_reg;
  logic [7:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic awready_reg;
  logic wready_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic arready_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic dec_valid_reg;
  logic [4:0] dec_op_reg;
  logic [1:0] dec_words_reg;
  logic [2:0] dec_cycles_reg;
  logic dec_cond_reg;
  logic dec_illegal_reg;
  logic [8:0] dec_field_reg;
  logic [15:0] dec_operand_reg;
  logic [15:0] rpt_cnt_reg;
  logic rpt_active_reg;
  logic [15:0] cur_w0;
  logic [15:0] cur_w1;
  logic dec_go;
  dsp_decoder_pkg::op_t cur_op;
  logic cur_cond;
  logic [8:0] cur_field;
  logic wr_fire;
  logic wr_hit;
  logic [31:0] result_word;
  logic [31:0] repeat_word;

  // ----------------------------------------
  // Hold pin synchroniser
  // ----------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hold_meta_reg <= 1'b0;
      hold_sync_reg <= 1'b0;
    end else begin
      hold_meta_reg <= hold_req;
      hold_sync_reg <= hold_meta_reg;
    end
  end

  // ----------------------------------------
  // Decode source and combinational decode
  // ----------------------------------------
  // The fetch path wins; a software trigger in the same cycle is dropped
  assign dec_go = instr_valid | go_reg;
  assign cur_w0 = instr_valid ? instr_word0 : word0_reg;
  assign cur_w1 = instr_valid ? instr_word1 : word1_reg;
  assign cur_op = dsp_decoder_pkg::decode_word(cur_w0);

  always_comb begin
    cur_cond = 1'b1;
    cur_field = 9'h000;
    case (cur_op)
      dsp_decoder_pkg::cond_branch_op,
      dsp_decoder_pkg::cond_call_op,
      dsp_decoder_pkg::cond_return_op: cur_cond = dsp_decoder_pkg::cond_holds(cur_w0, flags_reg);
      dsp_decoder_pkg::aux_compare_op: cur_field = {7'h00, cur_w0[1:0]};
      dsp_decoder_pkg::aux_modify_op: cur_field = {6'h00, cur_w0[2:0]};
      dsp_decoder_pkg::page_load_op: cur_field = cur_w0[8:0];
      dsp_decoder_pkg::repeat_imm_op: cur_field = {1'b0, cur_w0[7:0]};
      dsp_decoder_pkg::store_acc_high_op,
      dsp_decoder_pkg::store_acc_low_op: cur_field = {6'h00, cur_w0[10:8]};
      default: cur_field = {1'b0, cur_w0[7:0]};
    endcase
  end

  // ----------------------------------------
  // Decoded outputs
  // ----------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dec_valid_reg <= 1'b0;
      dec_op_reg <= 5'h00;
      dec_words_reg <= dsp_decoder_pkg::WORDS_ONE;
      dec_cycles_reg <= dsp_decoder_pkg::CYC_ONE;
      dec_cond_reg <= 1'b0;
      dec_illegal_reg <= 1'b0;
      dec_field_reg <= 9'h000;
      dec_operand_reg <= 16'h0000;
    end else begin
      dec_valid_reg <= dec_go;
      if (dec_go) begin
        dec_op_reg <= cur_op;
        dec_words_reg <= dsp_decoder_pkg::words_of(cur_op);
        dec_cycles_reg <= dsp_decoder_pkg::cycles_of(cur_op, cur_cond);
        dec_cond_reg <= cur_cond;
        dec_illegal_reg <= (cur_op == dsp_decoder_pkg::illegal_op);
        dec_field_reg <= cur_field;
        // Second word carries branch target or port address
        dec_operand_reg <= cur_w1;
      end
    end
  end

  // ----------------------------------------
  // Repeat counter
  // ----------------------------------------
  // Count N gives N+1 executions; hold pauses the count, keeps the mask
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rpt_cnt_reg <= dsp_decoder_pkg::RPT_RST;
      rpt_active_reg <= 1'b0;
    end else if (dec_go && !rpt_active_reg &&
                 cur_op == dsp_decoder_pkg::repeat_imm_op) begin
      rpt_cnt_reg <= {8'h00, cur_w0[7:0]};
      rpt_active_reg <= 1'b1;
    end else if (dec_go && !rpt_active_reg &&
                 cur_op == dsp_decoder_pkg::repeat_mem_op) begin
      rpt_cnt_reg <= rpt_mem_count;
      rpt_active_reg <= 1'b1;
    end else if (dec_go && rpt_active_reg && !hold_sync_reg) begin
      if (rpt_cnt_reg == 16'h0000) begin
        rpt_active_reg <= 1'b0;
      end else begin
        rpt_cnt_reg <= rpt_cnt_reg - 16'h0001;
      end
    end
  end

  // ----------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------
  assign wr_fire = aw_have_reg & w_have_reg & ~bvalid_reg;
  assign wr_hit = (aw_addr_reg == dsp_decoder_pkg::OFS_WORD0) |
                  (aw_addr_reg == dsp_decoder_pkg::OFS_WORD1) |
                  (aw_addr_reg == dsp_decoder_pkg::OFS_FLAGS) |
                  (aw_addr_reg == dsp_decoder_pkg::OFS_CMD);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      aw_have_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      awready_reg <= 1'b0;
    end else if (s_axi_awvalid && awready_reg) begin
      aw_have_reg <= 1'b1;
      aw_addr_reg <= {s_axi_awaddr[7:2], 2'h0};
      awready_reg <= 1'b0;
    end else if (wr_fire) begin
      aw_have_reg <= 1'b0;
    end else begin
      awready_reg <= ~aw_have_reg & ~bvalid_reg;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      w_have_reg <= 1'b0;
      w_data_reg <= 32'h00000000;
      w_strb_reg <= 4'h0;
      wready_reg <= 1'b0;
    end else if (s_axi_wvalid && wready_reg) begin
      w_have_reg <= 1'b1;
      w_data_reg <= s_axi_wdata;
      w_strb_reg <= s_axi_wstrb;
      wready_reg <= 1'b0;
    end else if (wr_fire) begin
      w_have_reg <= 1'b0;
    end else begin
      wready_reg <= ~w_have_reg & ~bvalid_reg;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= dsp_decoder_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= wr_hit ? dsp_decoder_pkg::RESP_OKAY : dsp_decoder_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  // ----------------------------------------
  // Software registers
  // ----------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      word0_reg <= dsp_decoder_pkg::WORD_RST;
      word1_reg <= 16'h0000;
      flags_reg <= dsp_decoder_pkg::FLAGS_RST;
    end else if (wr_fire) begin
      if (aw_addr_reg == dsp_decoder_pkg::OFS_WORD0) begin
        if (w_strb_reg[0]) word0_reg[7:0] <= w_data_reg[7:0];
        if (w_strb_reg[1]) word0_reg[15:8] <= w_data_reg[15:8];
      end
      if (aw_addr_reg == dsp_decoder_pkg::OFS_WORD1) begin
        if (w_strb_reg[0]) word1_reg[7:0] <= w_data_reg[7:0];
        if (w_strb_reg[1]) word1_reg[15:8] <= w_data_reg[15:8];
      end
      if (aw_addr_reg == dsp_decoder_pkg::OFS_FLAGS && w_strb_reg[0]) begin
        flags_reg <= w_data_reg[5:0];
      end
    end
  end

  // Trigger pulse lasts one cycle, so a stuck bit cannot re-decode forever
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      go_reg <= 1'b0;
    end else begin
      go_reg <= wr_fire & (aw_addr_reg == dsp_decoder_pkg::OFS_CMD) &
                w_strb_reg[0] & w_data_reg[0];
    end
  end

  // ----------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------
  assign result_word = {3'h0, dec_field_reg, 2'h0, dec_illegal_reg, dec_cond_reg,
                        1'b0, dec_cycles_reg, 2'h0, dec_words_reg, 3'h0, dec_op_reg};
  assign repeat_word = {15'h0000, rpt_active_reg, rpt_cnt_reg};

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      rresp_reg <= dsp_decoder_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && arready_reg) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b1;
      rresp_reg <= dsp_decoder_pkg::RESP_OKAY;
      case ({s_axi_araddr[7:2], 2'h0})
        dsp_decoder_pkg::OFS_WORD0: rdata_reg <= {16'h0000, word0_reg};
        dsp_decoder_pkg::OFS_WORD1: rdata_reg <= {16'h0000, word1_reg};
        dsp_decoder_pkg::OFS_FLAGS: rdata_reg <= {26'h0000000, flags_reg};
        dsp_decoder_pkg::OFS_CMD: rdata_reg <= 32'h00000000;
        dsp_decoder_pkg::OFS_RESULT: rdata_reg <= result_word;
        dsp_decoder_pkg::OFS_REPEAT: rdata_reg <= repeat_word;
        default: begin
          rdata_reg <= 32'h00000000;
          rresp_reg <= dsp_decoder_pkg::RESP_SLVERR;
        end
      endcase
    end else if (rvalid_reg) begin
      if (s_axi_rready) rvalid_reg <= 1'b0;
    end else begin
      arready_reg <= 1'b1;
    end
  end

  // ----------------------------------------
  // Output drive
  // ----------------------------------------
  assign dec_valid = dec_valid_reg;
  assign dec_op = dec_op_reg;
  assign dec_words = dec_words_reg;
  assign dec_cycles = dec_cycles_reg;
  assign dec_cond = dec_cond_reg;
  assign dec_illegal = dec_illegal_reg;
  assign dec_field = dec_field_reg;
  assign dec_operand = dec_operand_reg;
  assign irq_block = rpt_active_reg;
  assign rpt_active = rpt_active_reg;
  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign s_axi_rvalid = rvalid_reg;

endmodule // dsp_instruction_decoder

// file: dec_checker_properties.sv
// Assertions on the fetch-side outputs of the instruction decoder
`timescale 1ns/1ps
module dec_checker (
  input wire logic clk,
  input wire logic rst,
  input wire logic instr_valid,
  input wire logic [15:0] instr_word0,
  input wire logic dec_valid,
  input wire logic [4:0] dec_op,
  input wire logic [1:0] dec_words,
  input wire logic [2:0] dec_cycles,
  input wire logic dec_cond,
  input wire logic [8:0] dec_field,
  input wire logic irq_block,
  input wire logic rpt_active
);
  // ------------------------------
  // Helpers and properties
  // ------------------------------
  logic [10:0] low_q;
  // Opcode bits of the last fetch, for field checks one cycle on
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      low_q <= 11'h000;
    end else begin
      low_q <= instr_word0[10:0];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_issue(logic [7:0] b);
    instr_valid && instr_word0[15:8] == b;
  endsequence
  sequence s_shape(logic [4:0] op, logic [1:0] w, logic [2:0] c);
    dec_valid && dec_op == op && dec_words == w && dec_cycles == c;
  endsequence
  a_decode_latency: assert property (instr_valid |=> dec_valid)
    else $error("decode result missing after fetch");
  a_call_indirect: assert property (instr_valid && instr_word0 == 16'hBE30 |=>
    s_shape(dsp_decoder_pkg::call_indirect_op, 2'h1, 3'h4)) else $error("indirect call wrong");
  a_port_input: assert property (s_issue(8'hAF) |=>
    s_shape(dsp_decoder_pkg::port_in_op, 2'h2, 3'h2)) else $error("port input wrong");
  a_mac_move: assert property (s_issue(8'hA3) |=>
    s_shape(dsp_decoder_pkg::mac_move_op, 2'h2, 3'h3)) else $error("mac move wrong");
  a_page_load: assert property (instr_valid && instr_word0[15:9] == 7'h5E |=>
    s_shape(dsp_decoder_pkg::page_load_op, 2'h1, 3'h2) ##0 dec_field == low_q[8:0])
    else $error("page load wrong");
  a_aux_pointer: assert property (instr_valid && instr_word0[15:3] == 13'h1171 |=>
    dec_op == dsp_decoder_pkg::aux_modify_op && dec_field[2:0] == low_q[2:0])
    else $error("aux pointer load wrong");
  a_store_high: assert property (instr_valid && instr_word0[15:11] == 5'h13 |=>
    dec_op == dsp_decoder_pkg::store_acc_high_op && dec_field[2:0] == low_q[10:8])
    else $error("high store wrong");
  a_cond_cycles: assert property (dec_valid && (dec_op == dsp_decoder_pkg::cond_branch_op ||
    dec_op == dsp_decoder_pkg::cond_return_op) |-> dec_cycles == (dec_cond ? 3'h4 : 3'h2))
    else $error("conditional cycle count wrong");
  a_repeat_start: assert property (instr_valid && !rpt_active &&
    (instr_word0[15:8] == 8'hBB || instr_word0[15:8] == 8'h0B) |=> rpt_active)
    else $error("repeat loop not started");
  a_irq_masked: assert property (rpt_active |-> irq_block)
    else $error("interrupts open inside repeat loop");
endmodule // dec_checker

bind dsp_instruction_decoder dec_checker dec_checker_inst (.clk, .rst, .instr_valid,
  .instr_word0, .dec_valid, .dec_op, .dec_words, .dec_cycles, .dec_cond, .dec_field,
  .irq_block, .rpt_active);

// file: fetch_model.sv
// Fetch side model: issues opcode pairs and drives the hold pin
`timescale 1ns/1ps
module fetch_model (
  input wire logic clk,
  output logic instr_valid,
  output logic [15:0] instr_word0,
  output logic [15:0] instr_word1,
  output logic [15:0] rpt_mem_count,
  output logic hold_req
);
  initial begin
    instr_valid = 1'b0;
    instr_word0 = 16'h0000;
    instr_word1 = 16'h0000;
    rpt_mem_count = 16'h0000;
    hold_req = 1'b0;
  end
  // Words go inverted after the pulse so stale values cannot pass
  task automatic send(input logic [15:0] a, input logic [15:0] b = 16'h0000,
                      input logic [15:0] c = 16'h0000, input int n = 1);
    @(posedge clk);
    instr_valid <= 1'b1;
    instr_word0 <= a;
    instr_word1 <= b;
    rpt_mem_count <= c;
    repeat (n) @(posedge clk);
    instr_valid <= 1'b0;
    instr_word0 <= ~a;
    instr_word1 <= ~b;
    rpt_mem_count <= ~c;
  endtask
  // Two sync flops inside the core, so settle three cycles
  task automatic set_hold(input logic h);
    @(posedge clk);
    hold_req <= h;
    repeat (3) @(posedge clk);
  endtask
endmodule // fetch_model

// file: dsp_instruction_decoder_tb.sv
// Self-checking bench for the instruction decoder
`timescale 1ns/1ps
module dsp_instruction_decoder_tb;
  // ------------------------------
  // Signals and instances
  // ------------------------------
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic instr_valid, hold_req, dec_valid, dec_cond, dec_illegal, irq_block, rpt_active;
  logic [15:0] instr_word0, instr_word1, rpt_mem_count, dec_operand;
  logic [4:0] dec_op;
  logic [1:0] dec_words, s_axi_bresp, s_axi_rresp, resp;
  logic [2:0] dec_cycles;
  logic [8:0] dec_field;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [31:0] s_axi_rdata, data;
  int error_cnt = 0;
  int n_compared = 0;

  always #5 clk = ~clk;

  dsp_instruction_decoder dsp_instruction_decoder_inst (.clk, .rst, .instr_valid, .instr_word0,
    .instr_word1, .rpt_mem_count, .hold_req, .dec_valid, .dec_op, .dec_words, .dec_cycles,
    .dec_cond, .dec_illegal, .dec_field, .dec_operand, .irq_block, .rpt_active, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  fetch_model fetch_model_inst (.clk, .instr_valid, .instr_word0, .instr_word1,
    .rpt_mem_count, .hold_req);

  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // Bounded waits: a silent slave must not hang the run
  task automatic guard(input int n);
    if (n > 50) begin
      error_cnt++;
      tally_and_finish();
    end
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      n++;
      guard(n);
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e,
                      input logic [1:0] er = dsp_decoder_pkg::RESP_OKAY);
    int n;
    n = 0;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      n++;
      guard(n);
    end while (!s_axi_rvalid);
    chk(s_axi_rdata, e);
    chk(s_axi_rresp, er);
    s_axi_rready <= 1'b0;
  endtask
  task automatic setf(input logic [5:0] f);
    axw(dsp_decoder_pkg::OFS_FLAGS, {26'h0, f}, resp);
    chk(resp, dsp_decoder_pkg::RESP_OKAY);
  endtask
  task automatic dchk(input logic [15:0] w, input logic [4:0] op, input logic [1:0] nw = 2'h1,
                      input logic [2:0] nc = 3'h1, input logic cd = 1'b1);
    fetch_model_inst.send(w, 16'hA5C3);
    #1;
    chk(dec_valid, 1'b1);
    chk(dec_op, op);
    chk(dec_words, nw);
    chk(dec_cycles, nc);
    chk(dec_illegal, op == 5'h00);
    chk(dec_operand, 16'hA5C3);
    if (op != 5'h00) chk(dec_cond, cd);
  endtask
  // Opcodes 0xE0-0xE3 are branches, 0xEC-0xEF returns
  task automatic bchk(input logic [15:0] w, input logic t);
    dchk(w, w[11] ? dsp_decoder_pkg::cond_return_op : dsp_decoder_pkg::cond_branch_op,
         w[11] ? 2'h1 : 2'h2, t ? 3'h4 : 3'h2, t);
  endtask

  // ------------------------------
  // Scenarios
  // ------------------------------
  task automatic t_regs();
    rchk(dsp_decoder_pkg::OFS_FLAGS, 32'h20);
    rchk(dsp_decoder_pkg::OFS_REPEAT, 32'h0);
    rchk(dsp_decoder_pkg::OFS_RESULT, 32'h1100);
    rchk(8'h20, 32'h0, dsp_decoder_pkg::RESP_SLVERR);
    axw(8'h1C, 32'h1, resp);
    chk(resp, dsp_decoder_pkg::RESP_SLVERR);
    axw(dsp_decoder_pkg::OFS_WORD0, 32'hBE30, resp);
    axw(dsp_decoder_pkg::OFS_CMD, 32'h1, resp);
    rchk(dsp_decoder_pkg::OFS_RESULT, 32'h0301_4102);
  endtask
  task automatic t_table();
    dchk(16'hBE30, dsp_decoder_pkg::call_indirect_op, 2'h1, 3'h4);
    dchk(16'hBF45, dsp_decoder_pkg::aux_compare_op);
    chk(dec_field[1:0], 2'h1);
    dchk(16'hAF10, dsp_decoder_pkg::port_in_op, 2'h2, 3'h2);
    dchk(16'h6B05, dsp_decoder_pkg::load_acc_tshift_op);
    dchk(16'h8B8D, dsp_decoder_pkg::aux_modify_op);
    chk(dec_field[2:0], 3'h5);
    dchk(16'hBD23, dsp_decoder_pkg::page_load_op, 2'h1, 3'h2);
    chk(dec_field, 9'h123);
    dchk(16'h0E07, dsp_decoder_pkg::status_load_op, 2'h1, 3'h2);
    dchk(16'h7001, dsp_decoder_pkg::tload_accum_op);
    dchk(16'h7102, dsp_decoder_pkg::tload_prodmove_op);
    dchk(16'hA303, dsp_decoder_pkg::mac_move_op, 2'h2, 3'h3);
    dchk(16'h5004, dsp_decoder_pkg::mul_add_prev_op);
    dchk(16'h5105, dsp_decoder_pkg::mul_sub_prev_op);
    dchk(16'hA006, dsp_decoder_pkg::normalize_op);
    dchk(16'hBE3C, dsp_decoder_pkg::push_acc_op);
    dchk(16'hBE32, dsp_decoder_pkg::pop_acc_op);
    dchk(16'h9C00, dsp_decoder_pkg::store_acc_high_op);
    chk(dec_field[2:0], 3'h4);
    dchk(16'h9300, dsp_decoder_pkg::store_acc_low_op);
    chk(dec_field[2:0], 3'h3);
    dchk(16'hBE05, dsp_decoder_pkg::sub_product_op);
    dchk(16'h5307, dsp_decoder_pkg::square_sub_op);
    dchk(16'h6408, dsp_decoder_pkg::sub_borrow_op);
    dchk(16'h6809, dsp_decoder_pkg::zero_load_round_op);
    dchk(16'hFFFF, dsp_decoder_pkg::illegal_op);
  endtask
  task automatic t_cond();
    setf(6'h24);
    bchk(16'hE344, 1'b1);
    bchk(16'hE388, 1'b0);
    setf(6'h28);
    bchk(16'hE388, 1'b1);
    bchk(16'hE344, 1'b0);
    bchk(16'hE309, 1'b1);
    setf(6'h29);
    bchk(16'hE309, 1'b0);
    setf(6'h20);
    bchk(16'hEC00, 1'b0);
    bchk(16'hED00, 1'b0);
    bchk(16'hEE00, 1'b1);
    bchk(16'hEF00, 1'b1);
    setf(6'h10);
    bchk(16'hEC00, 1'b1);
    bchk(16'hED00, 1'b1);
    bchk(16'hEE00, 1'b0);
    dchk(16'hEB00, dsp_decoder_pkg::cond_call_op, 2'h2, 3'h4);
  endtask
  // Count 2 ends on the third later decode; held decodes must not count
  task automatic t_repeat();
    fetch_model_inst.send(16'hBB02);
    #1;
    chk({rpt_active, irq_block, dec_field}, {2'h3, 9'h002});
    rchk(dsp_decoder_pkg::OFS_REPEAT, 32'h0001_0002);
    fetch_model_inst.set_hold(1'b1);
    fetch_model_inst.send(16'h5000, 16'h0000, 16'h0000, 2);
    #1;
    chk(rpt_active, 1'b1);
    fetch_model_inst.set_hold(1'b0);
    fetch_model_inst.send(16'h5000, 16'h0000, 16'h0000, 2);
    #1;
    chk(irq_block, 1'b1);
    fetch_model_inst.send(16'h5000);
    #1;
    chk({rpt_active, irq_block}, 2'h0);
    fetch_model_inst.send(16'h0B10);
    #1;
    chk(rpt_active, 1'b1);
    fetch_model_inst.send(16'h5000);
    #1;
    chk(rpt_active, 1'b0);
  endtask

  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_table();
    t_cond();
    t_repeat();
    tally_and_finish();
  end
endmodule // dsp_instruction_decoder_tb
